// File: rtl/status_event_map.svh
// Bit positions, masks and reset values of the status event registers
`ifndef STATUS_EVENT_MAP_SVH
`define STATUS_EVENT_MAP_SVH

// ----------------------------------------------------------------------
// Standard event flags
// ----------------------------------------------------------------------
`define STD_OP_DONE_BIT 0
`define STD_QUERY_ERR_BIT 2
`define STD_FAULT_BIT 3
`define STD_EXEC_ERR_BIT 4
`define STD_CMD_ERR_BIT 5
`define STD_POWER_BIT 7
`define STD_USED_MASK 8'hbd
`define STD_RESET 8'h80
`define STD_ZERO 8'h00

// ----------------------------------------------------------------------
// Questionable data flags
// ----------------------------------------------------------------------
`define QUES_VOLT_BIT 0
`define QUES_CURR_BIT 1
`define QUES_OHMS_BIT 9
`define QUES_LIMIT_LO_BIT 11
`define QUES_LIMIT_HI_BIT 12
`define QUES_USED_MASK 16'h1a03
`define QUES_OVERLOAD_MASK 16'h0203
`define QUES_RESET 16'h0000
`define QUES_ENABLE_RESET 16'h0000

// ----------------------------------------------------------------------
// Output buffer response
// ----------------------------------------------------------------------
`define ASCII_ONE 8'h31
`define RESP_IDLE 8'h00

`endif

// File: rtl/status_event_pkg.sv
// Types shared by the status event register block
package status_event_pkg;

    typedef enum logic {
        MODE_IDLE,
        MODE_MEASURE
    } mode_e;

    typedef enum logic [3:0] {
        FUNC_DCV,
        FUNC_ACV,
        FUNC_FREQ,
        FUNC_PERIOD,
        FUNC_DIODE,
        FUNC_RATIO,
        FUNC_DCI,
        FUNC_ACI,
        FUNC_RES2,
        FUNC_RES4,
        FUNC_OTHER
    } func_e;

    typedef struct packed {
        mode_e mode;
        logic [7:0] std_flags;
        logic [15:0] ques_flags;
        logic [15:0] ques_enable;
        logic ques_summary;
        logic take_readings;
        logic opc_pending;
        logic opcq_pending;
        logic resp_valid;
        logic [7:0] resp_data;
    } state_s;

endpackage

// File: rtl/status_event_regs.sv
// Standard event and questionable data registers with operation-complete logic
//
// How it works
// - Operation-done flag set only by completion command
// - Query error on empty read, unread, overflow
// - Internal fault flag on internal operation failure
// - Execution error flag on command execution error
// - Command error on syntax, semantic, trigger
// - Power-cycled flag set after power restore
// - Completion command waits for pending operations
// - Completion query queues ASCII one when done
// - Leave-idle command starts measuring
// - Back to idle, then finish pending completions
// - Stop readings while output buffer full
// - Enabled questionable bits form summary flag
// - Summary only from enabled questionable events
// - Voltage-type overload sets questionable bit 0
// - Current overload sets questionable bit 1
// - Resistance overload sets questionable bit 9
// - Below lower limit sets questionable bit 11
// - Above upper limit sets questionable bit 12
// - Store questionable enable mask from controller
// - Overloads also set internal fault flag
`timescale 1ns/10ps
`include "status_event_map.svh"

module status_event_regs (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Common commands from the command parser, one-cycle pulses
    input wire logic OPC_CMD_I,
    input wire logic OPC_QUERY_I,
    input wire logic LEAVE_IDLE_CMD_I,
    input wire logic PROGRAM_DONE_I,
    input wire logic CLEAR_STATUS_I,
    input wire logic STD_READ_I,
    input wire logic QUES_READ_I,
    input wire logic QUES_ENABLE_WR_I,
    input wire logic [15:0] QUES_ENABLE_DATA_I,
    // Error events, one-cycle pulses
    input wire logic EMPTY_READ_I,
    input wire logic UNREAD_QUERY_I,
    input wire logic BUFFERS_FULL_I,
    input wire logic INTERNAL_FAULT_I,
    input wire logic EXEC_ERROR_I,
    input wire logic SYNTAX_ERROR_I,
    input wire logic SEMANTIC_ERROR_I,
    input wire logic TRIGGER_IN_MSG_I,
    // Measurement results
    input wire logic READING_VALID_I,
    input wire logic [3:0] READING_FUNC_I,
    input wire logic READING_OVERLOAD_I,
    input wire logic LIMIT_TEST_I,
    input wire logic BELOW_LOW_LIMIT_I,
    input wire logic ABOVE_HIGH_LIMIT_I,
    // Output buffer
    input wire logic OUT_BUF_FULL_I,
    input wire logic RESP_READY_I,
    output logic RESP_VALID_O,
    output logic [7:0] RESP_DATA_O,
    // Register contents and status
    output logic [7:0] STD_EVENT_O,
    output logic [15:0] QUES_EVENT_O,
    output logic [15:0] QUES_ENABLE_O,
    output logic QUES_SUMMARY_O,
    output logic MEASURING_O,
    output logic TAKE_READINGS_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam status_event_pkg::state_s RESET_STATE = '{
        mode: status_event_pkg::MODE_IDLE,
        std_flags: `STD_RESET,
        ques_flags: `QUES_RESET,
        ques_enable: `QUES_ENABLE_RESET,
        ques_summary: 1'b0,
        take_readings: 1'b0,
        opc_pending: 1'b0,
        opcq_pending: 1'b0,
        resp_valid: 1'b0,
        resp_data: `RESP_IDLE
    };

    status_event_pkg::state_s q;
    status_event_pkg::state_s d;

    logic [7:0] std_set;
    logic [15:0] ques_set;
    logic reading_taken;
    logic volt_func;
    logic curr_func;
    logic ohms_func;
    logic idle_now;
    logic opc_wait;
    logic opcq_wait;
    logic [7:0] std_keep;
    logic [15:0] ques_keep;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        std_set = `STD_ZERO;
        ques_set = `QUES_RESET;
        volt_func = 1'b0;
        curr_func = 1'b0;
        ohms_func = 1'b0;

        // A reading only counts while the block is willing to take one
        reading_taken = READING_VALID_I & q.take_readings;

        case (status_event_pkg::func_e'(READING_FUNC_I))
            status_event_pkg::FUNC_DCV,
            status_event_pkg::FUNC_ACV,
            status_event_pkg::FUNC_FREQ,
            status_event_pkg::FUNC_PERIOD,
            status_event_pkg::FUNC_DIODE,
            status_event_pkg::FUNC_RATIO:
                volt_func = 1'b1;
            status_event_pkg::FUNC_DCI,
            status_event_pkg::FUNC_ACI:
                curr_func = 1'b1;
            status_event_pkg::FUNC_RES2,
            status_event_pkg::FUNC_RES4:
                ohms_func = 1'b1;
            default:
                volt_func = 1'b0;
        endcase

        // --------------------------------------------------------------
        // Measurement mode
        // --------------------------------------------------------------
        case (q.mode)
            status_event_pkg::MODE_IDLE:
            begin
                if (LEAVE_IDLE_CMD_I)
                begin
                    d.mode = status_event_pkg::MODE_MEASURE;
                end
            end
            status_event_pkg::MODE_MEASURE:
            begin
                if (PROGRAM_DONE_I)
                begin
                    d.mode = status_event_pkg::MODE_IDLE;
                end
            end
            default:
            begin
                d.mode = status_event_pkg::MODE_IDLE;
            end
        endcase

        // Readings halt while the output buffer cannot take more
        d.take_readings = (d.mode == status_event_pkg::MODE_MEASURE) & ~OUT_BUF_FULL_I;

        // --------------------------------------------------------------
        // Operation complete handling
        // --------------------------------------------------------------
        // Pending operations are over only once the block sits idle
        idle_now = (q.mode == status_event_pkg::MODE_IDLE) & ~LEAVE_IDLE_CMD_I;
        opc_wait = q.opc_pending | OPC_CMD_I;
        opcq_wait = q.opcq_pending | OPC_QUERY_I;

        if (opc_wait & idle_now)
        begin
            std_set[`STD_OP_DONE_BIT] = 1'b1;
            d.opc_pending = 1'b0;
        end
        else
        begin
            d.opc_pending = opc_wait;
        end

        if (q.resp_valid & RESP_READY_I)
        begin
            d.resp_valid = 1'b0;
            d.resp_data = `RESP_IDLE;
        end

        // A held response blocks a second one rather than overwrite it
        if (opcq_wait & idle_now & ~d.resp_valid)
        begin
            d.resp_valid = 1'b1;
            d.resp_data = `ASCII_ONE;
            d.opcq_pending = 1'b0;
        end
        else
        begin
            d.opcq_pending = opcq_wait;
        end

        // --------------------------------------------------------------
        // Standard event sources
        // --------------------------------------------------------------
        std_set[`STD_QUERY_ERR_BIT] = EMPTY_READ_I | UNREAD_QUERY_I | BUFFERS_FULL_I;
        std_set[`STD_EXEC_ERR_BIT] = EXEC_ERROR_I;
        std_set[`STD_CMD_ERR_BIT] = SYNTAX_ERROR_I | SEMANTIC_ERROR_I
            | TRIGGER_IN_MSG_I;

        // --------------------------------------------------------------
        // Questionable data sources
        // --------------------------------------------------------------
        ques_set[`QUES_VOLT_BIT] = reading_taken & READING_OVERLOAD_I & volt_func;
        ques_set[`QUES_CURR_BIT] = reading_taken & READING_OVERLOAD_I & curr_func;
        ques_set[`QUES_OHMS_BIT] = reading_taken & READING_OVERLOAD_I & ohms_func;
        ques_set[`QUES_LIMIT_LO_BIT] = reading_taken & LIMIT_TEST_I
            & BELOW_LOW_LIMIT_I;
        ques_set[`QUES_LIMIT_HI_BIT] = reading_taken & LIMIT_TEST_I
            & ABOVE_HIGH_LIMIT_I;

        // Overloads echo into the fault flag; internal faults too
        std_set[`STD_FAULT_BIT] = INTERNAL_FAULT_I
            | (|(ques_set & `QUES_OVERLOAD_MASK));

        // --------------------------------------------------------------
        // Sticky update: a set in the clearing cycle survives
        // --------------------------------------------------------------
        std_keep = (CLEAR_STATUS_I | STD_READ_I) ? `STD_ZERO : q.std_flags;
        ques_keep = (CLEAR_STATUS_I | QUES_READ_I) ? `QUES_RESET : q.ques_flags;
        d.std_flags = (std_keep | std_set) & `STD_USED_MASK;
        d.ques_flags = (ques_keep | ques_set) & `QUES_USED_MASK;

        if (QUES_ENABLE_WR_I)
        begin
            d.ques_enable = QUES_ENABLE_DATA_I;
        end

        // Summary follows the updated flags so it agrees with them
        d.ques_summary = |(d.ques_flags & d.ques_enable);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset stands for power restore, so the power flag comes up set
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            q <= RESET_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign STD_EVENT_O = q.std_flags;
    assign QUES_EVENT_O = q.ques_flags;
    assign QUES_ENABLE_O = q.ques_enable;
    assign QUES_SUMMARY_O = q.ques_summary;
    assign MEASURING_O = (q.mode == status_event_pkg::MODE_MEASURE);
    assign TAKE_READINGS_O = q.take_readings;
    assign RESP_VALID_O = q.resp_valid;
    assign RESP_DATA_O = q.resp_data;

endmodule

// File: tb/status_event_props.sv
// Concurrent checks on the ports of the status event registers
`timescale 1ns/10ps
module status_event_props (
    // Clock, reset and commands
    input wire logic CLK_I, RESET_I, OPC_CMD_I, LEAVE_IDLE_CMD_I, PROGRAM_DONE_I,
    input wire logic CLEAR_STATUS_I, STD_READ_I, OUT_BUF_FULL_I, RESP_READY_I,
    // Error and reading causes
    input wire logic EMPTY_READ_I, UNREAD_QUERY_I, BUFFERS_FULL_I, INTERNAL_FAULT_I,
    input wire logic EXEC_ERROR_I, SYNTAX_ERROR_I, SEMANTIC_ERROR_I, TRIGGER_IN_MSG_I,
    input wire logic READING_VALID_I, READING_OVERLOAD_I,
    input wire logic [3:0] READING_FUNC_I,
    // Observed outputs
    input wire logic RESP_VALID_O, QUES_SUMMARY_O, MEASURING_O, TAKE_READINGS_O,
    input wire logic [7:0] RESP_DATA_O, STD_EVENT_O,
    input wire logic [15:0] QUES_EVENT_O, QUES_ENABLE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    property p_opc; OPC_CMD_I && !MEASURING_O && !LEAVE_IDLE_CMD_I |=> STD_EVENT_O[0]; endproperty
    a_opc: assert property (p_opc) else $error("done flag not set");
    property p_defer; MEASURING_O && !PROGRAM_DONE_I && !STD_EVENT_O[0] |=> !STD_EVENT_O[0];
    endproperty
    a_defer: assert property (p_defer) else $error("done flag early");
    property p_qerr; EMPTY_READ_I || UNREAD_QUERY_I || BUFFERS_FULL_I |=> STD_EVENT_O[2];
    endproperty
    a_qerr: assert property (p_qerr) else $error("query error missing");
    property p_fault; INTERNAL_FAULT_I |=> STD_EVENT_O[3]; endproperty
    a_fault: assert property (p_fault) else $error("fault flag missing");
    property p_exec; EXEC_ERROR_I |=> STD_EVENT_O[4]; endproperty
    a_exec: assert property (p_exec) else $error("exec flag missing");
    property p_cmd; SYNTAX_ERROR_I || SEMANTIC_ERROR_I || TRIGGER_IN_MSG_I |=> STD_EVENT_O[5];
    endproperty
    a_cmd: assert property (p_cmd) else $error("command flag missing");
    property p_sticky; STD_EVENT_O[4] && !CLEAR_STATUS_I && !STD_READ_I |=> STD_EVENT_O[4];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_unused; !STD_EVENT_O[1] && !STD_EVENT_O[6] && (QUES_EVENT_O & ~16'h1a03) == 16'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    property p_sum; QUES_SUMMARY_O == |(QUES_EVENT_O & QUES_ENABLE_O); endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");
    property p_start; LEAVE_IDLE_CMD_I && !MEASURING_O |=> MEASURING_O; endproperty
    a_start: assert property (p_start) else $error("did not start");
    property p_full; OUT_BUF_FULL_I |=> !TAKE_READINGS_O; endproperty
    a_full: assert property (p_full) else $error("readings while full");
    property p_ohms; READING_VALID_I && TAKE_READINGS_O && READING_OVERLOAD_I
        && READING_FUNC_I == 4'h8 |=> QUES_EVENT_O[9] && STD_EVENT_O[3]; endproperty
    a_ohms: assert property (p_ohms) else $error("ohms overload lost");
    property p_resp; RESP_VALID_O |-> RESP_DATA_O == 8'h31; endproperty
    a_resp: assert property (p_resp) else $error("response data wrong");
    c_resp: cover property (RESP_VALID_O && RESP_READY_I);
    c_sum: cover property (QUES_SUMMARY_O);
    c_meas: cover property ($rose(MEASURING_O));
endmodule

bind status_event_regs status_event_props status_event_props_inst (.*);

// File: tb/resp_sink.sv
// Output buffer side that takes queued responses, promptly or after a stall
`timescale 1ns/10ps
module resp_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic valid_i,
    output logic ready_o
);
    logic [1:0] wait_q;
    // A stalled buffer holds off three cycles before it takes the response
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !valid_i || ready_o)
            wait_q <= 2'h0;
        else if (wait_q != 2'h3)
            wait_q <= wait_q + 2'h1;
    end
    assign ready_o = valid_i && (!slow_i || wait_q == 2'h3);
endmodule

// File: tb/tb_instrument_status_event_registers.sv
// Self-checking bench for the status event registers
`timescale 1ns/10ps
module tb_instrument_status_event_registers;
    logic clk = 1'b0, rst = 1'b1, leave = 1'b0, done = 1'b0, clr = 1'b0, srd = 1'b0;
    logic qwr = 1'b0, opcq = 1'b0, rv = 1'b0, ovl = 1'b0, lim = 1'b0, lo = 1'b0, hi = 1'b0;
    logic full = 1'b0, slow = 1'b0, qrd = 1'b0, ready, resp_valid, measuring, take, summary;
    logic [8:0] ev = 9'h0;
    logic [3:0] func = 4'h0;
    logic [7:0] resp_data, std;
    logic [15:0] qdata = 16'h0, ques, qen, expq;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    typedef struct packed {logic [8:0] cause; logic [7:0] exp;} row_t;
    row_t rows [9] = '{'{9'h100, 8'h01}, '{9'h001, 8'h04}, '{9'h002, 8'h04}, '{9'h004, 8'h04},
        '{9'h008, 8'h08}, '{9'h020, 8'h20}, '{9'h040, 8'h20}, '{9'h080, 8'h20}, '{9'h010, 8'h10}};

    status_event_regs status_event_regs_inst (.CLK_I(clk), .RESET_I(rst), .OPC_CMD_I(ev[8]),
        .OPC_QUERY_I(opcq), .LEAVE_IDLE_CMD_I(leave), .PROGRAM_DONE_I(done),
        .CLEAR_STATUS_I(clr), .STD_READ_I(srd), .QUES_READ_I(qrd), .QUES_ENABLE_WR_I(qwr),
        .QUES_ENABLE_DATA_I(qdata), .EMPTY_READ_I(ev[0]), .UNREAD_QUERY_I(ev[1]),
        .BUFFERS_FULL_I(ev[2]), .INTERNAL_FAULT_I(ev[3]), .EXEC_ERROR_I(ev[4]),
        .SYNTAX_ERROR_I(ev[5]), .SEMANTIC_ERROR_I(ev[6]), .TRIGGER_IN_MSG_I(ev[7]),
        .READING_VALID_I(rv), .READING_FUNC_I(func), .READING_OVERLOAD_I(ovl),
        .LIMIT_TEST_I(lim), .BELOW_LOW_LIMIT_I(lo), .ABOVE_HIGH_LIMIT_I(hi),
        .OUT_BUF_FULL_I(full), .RESP_READY_I(ready), .RESP_VALID_O(resp_valid),
        .RESP_DATA_O(resp_data), .STD_EVENT_O(std), .QUES_EVENT_O(ques), .QUES_ENABLE_O(qen),
        .QUES_SUMMARY_O(summary), .MEASURING_O(measuring), .TAKE_READINGS_O(take));
    resp_sink resp_sink_inst (.clk_i(clk), .rst_i(rst), .slow_i(slow), .valid_i(resp_valid),
        .ready_o(ready));

    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Clearing in the same cycle isolates the new flag, since a set wins over a clear
    // Idle cycle after each reading so strobes never toggle twice in one step
    task automatic rd(input logic [3:0] f, input logic o, input logic l, input logic h);
        func = f; ovl = o; lim = 1'b1; lo = l; hi = h; rv = 1'b1; clr = 1'b1;
        tick();
        rv = 1'b0; clr = 1'b0;
        tick();
    endtask
    task automatic wrap_up();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
        forever #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (2) tick();
        rst = 1'b0;
        chk({measuring, qen}, 17'h0);
        chk({ques, std}, {16'h0, 8'h80});
        foreach (rows[i])
        begin
            ev = rows[i].cause; clr = 1'b1;
            tick();
            ev = 9'h0; clr = 1'b0;
            tick();
            chk(std, rows[i].exp);
        end
        tick();
        chk(std, 8'h10);
        srd = 1'b1;
        tick();
        srd = 1'b0;
        chk(std, 8'h00);
        leave = 1'b1; qwr = 1'b1; qdata = 16'h0200;
        tick();
        leave = 1'b0; qwr = 1'b0;
        chk({qen, measuring, take}, {16'h0200, 2'h3});
        for (int f = 0; f <= 10; f++)
        begin
            rd(f[3:0], 1'b1, 1'b0, 1'b0);
            expq = f <= 5 ? 16'h0001 : f <= 7 ? 16'h0002 : f <= 9 ? 16'h0200 : 16'h0;
            chk({summary, ques}, {expq[9], expq});
            chk(std, (expq != 16'h0) ? 8'h08 : 8'h00);
        end
        rd(4'h0, 1'b0, 1'b1, 1'b0);
        chk(ques, 16'h0800);
        rd(4'h0, 1'b0, 1'b0, 1'b1);
        chk({summary, ques}, {1'b0, 16'h1000});
        qrd = 1'b1;
        tick();
        qrd = 1'b0;
        chk({summary, ques}, 17'h0);
        full = 1'b1;
        tick();
        rd(4'h8, 1'b1, 1'b0, 1'b0);
        chk({take, ques}, 17'h0);
        full = 1'b0; ev = 9'h100; opcq = 1'b1; slow = 1'b1;
        tick();
        ev = 9'h0; opcq = 1'b0;
        repeat (3) tick();
        chk({resp_valid, std}, 9'h0);
        done = 1'b1;
        tick();
        done = 1'b0;
        chk(measuring, 1'b0);
        tick();
        chk({resp_valid, resp_data, std}, {1'b1, 8'h31, 8'h01});
        for (int k = 0; k < 8 && resp_valid === 1'b1; k++)
            tick();
        chk(resp_valid, 1'b0);
        slow = 1'b0; opcq = 1'b1;
        tick();
        opcq = 1'b0;
        chk({resp_valid, resp_data}, 9'h131);
        tick();
        chk(resp_valid, 1'b0);
        // Second power restore while idle: mask must drop, mode stay idle, power flag return
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        chk({measuring, take, resp_valid, qen}, 19'h0);
        chk({ques, std}, {16'h0, 8'h80});
        tick();
        chk(std, 8'h80);
        wrap_up();
    end
endmodule
